/* code_monitor.sv */
// Behaviour
// - code register bit 6 selects low 0.6 V input threshold when set.
// - code register bit 7 selects shared pin as sixth code input.
// - sixth code input mode disables high-supply monitoring on that pin.
// - bit 5 of code register reads zero when pin select cleared.
// - bit 5 returns live shared pin level when pin select set.
// - status two bit 0 shows high-supply out of limits when select cleared.
// - status two bit 0 shows code change when select set.
// - change detection runs only in sixth code input mode.
// - change flag sets when inputs differ from the snapshot taken at the start of the current 11 us window.
// - code change raises alert unless mask two bit 0 set.
// - measurement codes are 10-bit unsigned, saturating at 1023, nominal 768.
// - with 5 V supply select, five_volt_supply is set; device supply code passes through unscaled.
// - code register bits 0..4 return live five dedicated code pins.
// - host reads status; alert releases only when cause has gone.
`timescale 1ns/1ps
`include "code_monitor_cfg.svh"

module code_monitor
  import code_monitor_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire code_monitor_pkg::reg_req_t   req,
  output logic [7:0]                        rdata,
  input  wire logic [4:0]                   code_pins,
  input  wire logic                         shared_pin,
  input  wire logic                         supply_high_out_of_limit,
  input  wire code_monitor_pkg::adc_codes_t adc_raw,
  output code_monitor_pkg::adc_codes_t      adc_codes,
  output logic                              threshold_select,
  output logic                              supply_high_monitor_en,
  output logic                              five_volt_supply,
  output logic                              smbalert_n
);
  import code_monitor_pkg::*;

  logic [7:0] code_cfg_q;
  logic [7:0] code_cfg_d;
  logic [7:0] cfg1_q;
  logic [7:0] cfg1_d;
  logic [7:0] mask2_q;
  logic [7:0] mask2_d;
  logic       flag_q;
  logic       flag_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  adc_codes_t adc_q;
  adc_codes_t adc_d;
  logic       pin_function_select;
  logic       sixth_code_input;
  logic       change;
  logic       status_read;
  logic [7:0] code_read;
  logic [7:0] status_read_val;

  assign pin_function_select = code_cfg_q[`CODE_PINSEL_BIT];
  assign sixth_code_input = pin_function_select & shared_pin;
  assign status_read = req.rd && req.addr == `ADDR_STATUS_TWO;

  code_change_detect code_change_detect_i
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .enable  (pin_function_select),
    .code_in ({sixth_code_input, code_pins}),
    .change  (change)
  );

  always_comb
  begin
    code_read = {code_cfg_q[7:6], sixth_code_input, code_pins};
    status_read_val = {7'h00, pin_function_select ? flag_q : supply_high_out_of_limit};
  end

  always_comb
  begin
    code_cfg_d = code_cfg_q;
    cfg1_d     = cfg1_q;
    mask2_d    = mask2_q;
    rdata_d    = rdata_q;
    flag_d     = flag_q;
    if (req.wr)
    begin
      case (req.addr)
        `ADDR_CODE_CONFIG: code_cfg_d = {req.wdata[7:6], 6'h00};
        `ADDR_CONFIG_ONE:  cfg1_d     = req.wdata;
        `ADDR_MASK_TWO:    mask2_d    = req.wdata;
        default:           code_cfg_d = code_cfg_q;
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        `ADDR_CODE_CONFIG: rdata_d = code_read;
        `ADDR_STATUS_TWO:  rdata_d = status_read_val;
        `ADDR_CONFIG_ONE:  rdata_d = cfg1_q;
        `ADDR_MASK_TWO:    rdata_d = mask2_q;
        default:           rdata_d = 8'h00;
      endcase
    end
    // clear on status read, set wins
    if (status_read)
      flag_d = 1'b0;
    if (!pin_function_select)
      flag_d = 1'b0;
    if (change)
      flag_d = 1'b1;
  end

  function automatic logic [9:0] sat10(input logic [9:0] v);
    sat10 = (v > `ADC_MAX_CODE) ? `ADC_MAX_CODE : v;
  endfunction

  always_comb
  begin
    adc_d.five_volt     = sat10(adc_raw.five_volt);
    adc_d.device_supply = sat10(adc_raw.device_supply);
    // no high-supply result in code mode
    adc_d.supply_high   = pin_function_select ? 10'h000 : sat10(adc_raw.supply_high);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_cfg_q <= `CODE_CONFIG_RESET;
      cfg1_q     <= `CONFIG_ONE_RESET;
      mask2_q    <= `MASK_TWO_RESET;
      flag_q     <= 1'b0;
      rdata_q    <= 8'h00;
      adc_q      <= '0;
    end
    else
    begin
      code_cfg_q <= code_cfg_d;
      cfg1_q     <= cfg1_d;
      mask2_q    <= mask2_d;
      flag_q     <= flag_d;
      rdata_q    <= rdata_d;
      adc_q      <= adc_d;
    end
  end

  assign rdata = rdata_q;
  assign adc_codes = adc_q;
  assign threshold_select = code_cfg_q[`CODE_THRESH_BIT];
  assign supply_high_monitor_en = ~pin_function_select;
  assign five_volt_supply = cfg1_q[`CFG1_FIVE_VOLT_BIT];
  assign smbalert_n = ~(flag_q & ~mask2_q[`MASK2_CHANGE_BIT]);

  a_flag_sets : assert property (@(posedge clk) disable iff (!rst_n)
    change |=> flag_q)
    else $error("change not latched");
  a_flag_holds : assert property (@(posedge clk) disable iff (!rst_n)
    (flag_q && pin_function_select && !status_read && !change) |=> flag_q)
    else $error("flag dropped without status read");
  a_flag_clear : assert property (@(posedge clk) disable iff (!rst_n)
    (status_read && !change) |=> !flag_q)
    else $error("flag not cleared by status read");
  a_flag_off : assert property (@(posedge clk) disable iff (!rst_n)
    (!pin_function_select && !change) |=> !flag_q)
    else $error("flag set while detection off");
  a_alert_mask : assert property (@(posedge clk) disable iff (!rst_n)
    mask2_q[`MASK2_CHANGE_BIT] |-> smbalert_n)
    else $error("alert despite mask");
  a_alert_raise : assert property (@(posedge clk) disable iff (!rst_n)
    (change && !mask2_q[`MASK2_CHANGE_BIT] && !(req.wr && req.addr == `ADDR_MASK_TWO)) |=> !smbalert_n)
    else $error("alert not raised on change");
  a_alert_release : assert property (@(posedge clk) disable iff (!rst_n)
    (status_read && !change) |=> smbalert_n)
    else $error("alert held after status read");
  a_mask_store : assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `ADDR_MASK_TWO) |=> mask2_q == $past(req.wdata))
    else $error("mask register not stored");
  a_thresh_write : assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `ADDR_CODE_CONFIG) |=> threshold_select == $past(req.wdata[`CODE_THRESH_BIT]))
    else $error("threshold select not stored");
  a_pinsel_write : assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `ADDR_CODE_CONFIG) |=> pin_function_select == $past(req.wdata[`CODE_PINSEL_BIT]))
    else $error("pin function select not stored");
  a_monitor_off : assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `ADDR_CODE_CONFIG && req.wdata[`CODE_PINSEL_BIT]) |=> !supply_high_monitor_en)
    else $error("supply monitor still enabled in code mode");
  a_code_live : assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.addr == `ADDR_CODE_CONFIG) |=> rdata[4:0] == $past(code_pins))
    else $error("dedicated code bits not live");
  a_sixth_zero : assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.addr == `ADDR_CODE_CONFIG && !pin_function_select) |=> rdata[`CODE_SIXTH_BIT] == 1'b0)
    else $error("sixth bit nonzero with select clear");
  a_sixth_live : assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.addr == `ADDR_CODE_CONFIG && pin_function_select) |=> rdata[5:0] == $past({shared_pin, code_pins}))
    else $error("code bits not live");
  a_status_mux : assert property (@(posedge clk) disable iff (!rst_n)
    (status_read && !pin_function_select) |=> rdata[0] == $past(supply_high_out_of_limit))
    else $error("status bit 0 not supply limit");
  a_status_flag : assert property (@(posedge clk) disable iff (!rst_n)
    (status_read && pin_function_select) |=> rdata[0] == $past(flag_q))
    else $error("status bit 0 not change flag");
  a_unmapped_zero : assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && !(req.addr inside {`ADDR_STATUS_TWO, `ADDR_CODE_CONFIG, `ADDR_CONFIG_ONE, `ADDR_MASK_TWO}))
      |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_five_volt : assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `ADDR_CONFIG_ONE) |=> five_volt_supply == $past(req.wdata[`CFG1_FIVE_VOLT_BIT]))
    else $error("five volt select not stored");
  a_adc_pass : assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> adc_codes.device_supply == $past(adc_raw.device_supply))
    else $error("device supply code not passed");
  a_supply_off : assert property (@(posedge clk) disable iff (!rst_n)
    pin_function_select |=> adc_codes.supply_high == 10'h000)
    else $error("supply result while in code mode");
endmodule

/* code_monitor_cfg.svh */
`ifndef CODE_MONITOR_CFG_SVH
`define CODE_MONITOR_CFG_SVH

`define ADDR_STATUS_TWO      8'h42
`define ADDR_CODE_CONFIG     8'h43
`define ADDR_CONFIG_ONE      8'h40
`define ADDR_MASK_TWO        8'h75
`define CODE_THRESH_BIT      6
`define CODE_PINSEL_BIT      7
`define CODE_SIXTH_BIT       5
`define CFG1_FIVE_VOLT_BIT   7
`define MASK2_CHANGE_BIT     0
`define CODE_CONFIG_RESET    8'h00
`define CONFIG_ONE_RESET     8'h00
`define MASK_TWO_RESET       8'h00
`define CLK_PERIOD_NS        10
`define CHANGE_WINDOW_NS     11000
`define CHANGE_WINDOW_CYC    ((`CHANGE_WINDOW_NS) / (`CLK_PERIOD_NS))
`define ADC_MAX_CODE         10'h3ff
`define ADC_NOMINAL_CODE     10'h300

`endif

/* code_monitor_pkg.sv */
package code_monitor_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [9:0] supply_high;
    logic [9:0] device_supply;
    logic [9:0] five_volt;
  } adc_codes_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACTIVE = 2'b10
  } detect_state_t;

endpackage

/* code_change_detect.sv */
`timescale 1ns/1ps
`include "code_monitor_cfg.svh"

module code_change_detect
  import code_monitor_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [5:0] code_in,
  output logic            change
);
  import code_monitor_pkg::*;

  localparam logic [10:0] WIN_LAST = 11'(`CHANGE_WINDOW_CYC - 1);

  detect_state_t state_q;
  detect_state_t state_d;
  logic [10:0]   cnt_q;
  logic [10:0]   cnt_d;
  logic [5:0]    snap_q;
  logic [5:0]    snap_d;
  logic          change_q;
  logic          change_d;

  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    snap_d   = snap_q;
    change_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        cnt_d  = 11'h000;
        snap_d = code_in;
        if (enable)
          state_d = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        change_d = (code_in != snap_q);
        if (cnt_q == WIN_LAST)
        begin
          cnt_d  = 11'h000;
          snap_d = code_in;
        end
        else
          cnt_d = cnt_q + 11'h001;
        if (!enable)
        begin
          state_d  = ST_IDLE;
          change_d = 1'b0;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= ST_IDLE;
      cnt_q    <= 11'h000;
      snap_q   <= 6'h00;
      change_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      snap_q   <= snap_d;
      change_q <= change_d;
    end
  end

  assign change = change_q;

  a_refresh_period : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_ACTIVE && cnt_q == WIN_LAST && enable) |=> cnt_q == 11'h000 && snap_q == $past(code_in))
    else $error("snapshot not refreshed at window end");
  a_idle_quiet : assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !change_q)
    else $error("change reported while detection off");
endmodule

/* smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model
  import code_monitor_pkg::*;
(
  input  wire logic                       clk,
  output code_monitor_pkg::reg_req_t      req,
  input  wire logic [7:0]                 rdata
);
  import code_monitor_pkg::*;
  initial req = '0;
  task automatic write(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk);
    req = '0;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    v = rdata;
  endtask
endmodule

/* voltage_code_input_monitor_bench.sv */
`timescale 1ns/1ps
module voltage_code_input_monitor_bench;
  import code_monitor_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       shared_pin = 1'b1;
  logic       lim = 1'b1;
  logic [4:0] code_pins = 5'h15;
  adc_codes_t adc_raw = '{10'h3ff, 10'h300, 10'h300};
  adc_codes_t adc_codes;
  reg_req_t   req;
  logic [7:0] rdata;
  logic [7:0] d;
  logic       thr;
  logic       mon_en;
  logic       five_v;
  logic       smbalert_n;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  always #5 clk = ~clk;
  code_monitor code_monitor_i (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .code_pins(code_pins),
    .shared_pin(shared_pin), .supply_high_out_of_limit(lim), .adc_raw(adc_raw),
    .adc_codes(adc_codes), .threshold_select(thr), .supply_high_monitor_en(mon_en),
    .five_volt_supply(five_v), .smbalert_n(smbalert_n)
  );
  smbus_host_model smbus_host_model_i (.clk(clk), .req(req), .rdata(rdata));
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    smbus_host_model_i.read(a, d);
    chk($sformatf("reg %h", a), {2'b00, e}, {2'b00, d & m});
  endtask
  task automatic wait_alert;
    for (int i = 0; i < 1500; i++)
    begin
      @(negedge clk);
      if (smbalert_n === 1'b0)
        return;
    end
    n_mismatch++;
    $display("[ERR] alert wait expected 0 seen %b", smbalert_n);
    end_of_test();
  endtask
  task automatic settle;
    repeat (2300) @(negedge clk);
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rchk(8'h43, 8'hff, 8'h15);
    chk("alert", 10'h1, {9'h0, smbalert_n});
    smbus_host_model_i.write(8'h43, 8'h40);
    chk("thr", 10'h1, {9'h0, thr});
    rchk(8'h43, 8'hff, 8'h55);
    rchk(8'h42, 8'h01, 8'h01);
    rchk(8'h10, 8'hff, 8'h00);
    smbus_host_model_i.write(8'h43, 8'hc0);
    chk("mon_en", 10'h0, {9'h0, mon_en});
    @(negedge clk);
    chk("sh_code", 10'h0, adc_codes.supply_high);
    rchk(8'h43, 8'hff, 8'hf5);
    lim = 1'b0;
    settle();
    smbus_host_model_i.read(8'h42, d);
    rchk(8'h42, 8'h01, 8'h00);
    chk("alert", 10'h1, {9'h0, smbalert_n});
    code_pins = 5'h14;
    wait_alert();
    settle();
    chk("alert", 10'h0, {9'h0, smbalert_n});
    rchk(8'h42, 8'h01, 8'h01);
    chk("alert", 10'h1, {9'h0, smbalert_n});
    smbus_host_model_i.write(8'h75, 8'h01);
    shared_pin = 1'b0;
    settle();
    chk("alert", 10'h1, {9'h0, smbalert_n});
    rchk(8'h42, 8'h01, 8'h01);
    smbus_host_model_i.write(8'h43, 8'h00);
    code_pins = 5'h15;
    settle();
    rchk(8'h42, 8'h01, 8'h00);
    chk("mon_en", 10'h1, {9'h0, mon_en});
    smbus_host_model_i.write(8'h40, 8'h80);
    chk("five_v", 10'h1, {9'h0, five_v});
    repeat (3) @(negedge clk);
    chk("sh", 10'h3ff, adc_codes.supply_high);
    chk("dev", 10'h300, adc_codes.device_supply);
    chk("five", 10'h300, adc_codes.five_volt);
    end_of_test();
  end
endmodule
